// file: hw/rtc_ctrl.sv
// timekeeping, alarm, watchdog and interrupt registers behind the byte bus
// assumes all pins are asynchronous to clk; date comes from same-clock logic
// Overview of operation
// [R1] minutes and seconds count BCD 00 to 59
// [R2] hours count BCD 00 to 23
// [R3] halt bit stops the oscillator timebase
// [R4] power-up without backup clears halt bit
// [R5] calibration sign adds or subtracts magnitude
// [R6] strobe reloads watchdog, self-clears, reads zero
// [R7] lock bit protects time-out field, reads zero
// [R8] new time-out loads on next watchdog tick
// [R9] period is value times 31.25 ms; zero disables
// [R10] watchdog interrupt enable gates expiry onto output
// [R11] alarm interrupt enable gates match onto output
// [R12] alarm interrupt in backup only when enabled
// [R13] polarity bit: push-pull high or open-drain low
// [R14] date mask excludes date from alarm compare
// [R15] hours mask excludes hours from alarm compare
// [R16] alarm flag sets on match, clears on read
// [R17] watchdog flag sets on expiry, clears on read
// [R18] power-fail enable gates detection onto output
// [R19] pulse mode 200 ms, else level until read
// [R20] host writes zeros, strobes watchdog in time
`timescale 1ns/100ps
module rtc_ctrl
    import rtc_ctrl_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_wr_data,
    output logic [7:0] dq_rd_data,
    output logic dq_oe_n,
    input wire logic e_n,
    input wire logic w_n,
    input wire logic g_n,
    input wire logic xtal_clk,
    input wire logic vcc_low,
    input wire logic nobackup_powerup,
    input wire logic [7:0] date_bcd,
    output logic int_data,
    output logic int_oe_n
);

    logic [30:0] pin_meta_ff;
    logic [30:0] pin_sync_ff;
    logic [16:0] addr_s;
    logic [7:0] dq_s;
    logic e_s, w_s, g_s, xtal_s, vcc_s, nobk_s;
    bus_state_t state_ff, nxt_state;
    logic [16:0] wr_addr_ff, rd_addr_ff;
    logic [7:0] wr_data_ff, dq_o_ff, nxt_dq_o;
    logic bus_exit, wr_stb, rd_clr;
    logic xtal_prev_ff, nobk_prev_ff, vcc_prev_ff, xtal_rise, nobk_rise;
    logic [7:0] sec_ff, min_ff, hour_ff, alm_hour_ff, alm_date_ff, osc_cal_ff, int_ctrl_ff;
    logic [16:0] sub_ff, sec_len;
    logic sec_tick, osc_halt, alm_chk_ff;
    logic [9:0] wd_pre_ff;
    logic [5:0] wdt_val_ff, wd_cnt_ff;
    logic wdt_pend_ff, kick_pend_ff, wd_tick, wd_ev, al_ev, pf_ev, irq_ev;
    logic [2:0] flags_ff;
    logic int_act_ff;
    logic [31:0] pulse_cnt_ff;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last);
        logic [7:0] r;
        r = 8'h00;
        if (v == last)
            r = 8'h00;
        else if (v[3:0] == 4'h9)
            r = {v[7:4] + 4'h1, 4'h0};
        else
            r = {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    // two-flop synchroniser for every pin except clk, rst and date_bcd
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end
        else
        begin
            pin_meta_ff <= {addr, dq_wr_data, e_n, w_n, g_n, xtal_clk, vcc_low, nobackup_powerup};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    assign {addr_s, dq_s, e_s, w_s, g_s, xtal_s, vcc_s, nobk_s} = pin_sync_ff;

    // bus cycle tracking
    always_comb
    begin
        nxt_state = state_ff;
        bus_exit = 1'b0;
        case (state_ff)
            BUS_IDLE:
            begin
                if (!e_s && !w_s)
                    nxt_state = BUS_WRITE;
                else if (!e_s && !g_s)
                    nxt_state = BUS_READ;
            end
            BUS_READ:
            begin
                bus_exit = e_s || g_s || !w_s;
                if (bus_exit)
                    nxt_state = BUS_IDLE;
            end
            BUS_WRITE:
            begin
                bus_exit = e_s || w_s;
                if (bus_exit)
                    nxt_state = BUS_IDLE;
            end
            default: nxt_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_ff <= BUS_IDLE;
        else
            state_ff <= nxt_state;
    end

    // last address and data seen while the write is still active
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_addr_ff <= '0;
            wr_data_ff <= RST_REG8;
            rd_addr_ff <= '0;
        end
        else
        begin
            if (!e_s && !w_s)
            begin
                wr_addr_ff <= addr_s;
                wr_data_ff <= dq_s;
            end
            if (state_ff == BUS_READ && !bus_exit)
                rd_addr_ff <= addr_s;
        end
    end
    assign wr_stb = (state_ff == BUS_WRITE) && bus_exit;
    assign rd_clr = (state_ff == BUS_READ) && bus_exit && (rd_addr_ff == OFS_FLAGS); // R16 R17

    always_comb
    begin
        case (addr_s)
            OFS_FLAGS: nxt_dq_o = {flags_ff, 5'h00};
            OFS_ALM_HOURS: nxt_dq_o = alm_hour_ff;
            OFS_ALM_DATE: nxt_dq_o = alm_date_ff;
            OFS_INT_CTRL: nxt_dq_o = int_ctrl_ff;
            OFS_WDOG: nxt_dq_o = {2'b00, wdt_val_ff}; // R6 R7
            OFS_OSC_CAL: nxt_dq_o = osc_cal_ff;
            OFS_SECONDS: nxt_dq_o = sec_ff;
            OFS_MINUTES: nxt_dq_o = min_ff;
            OFS_HOURS: nxt_dq_o = hour_ff;
            default: nxt_dq_o = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            dq_o_ff <= RST_REG8;
        else
            dq_o_ff <= nxt_dq_o;
    end
    assign dq_rd_data = dq_o_ff;
    assign dq_oe_n = (state_ff != BUS_READ);

    // crystal edges and pin event detection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            xtal_prev_ff <= 1'b0;
            nobk_prev_ff <= 1'b0;
            vcc_prev_ff <= 1'b0;
        end
        else
        begin
            xtal_prev_ff <= xtal_s;
            nobk_prev_ff <= nobk_s;
            vcc_prev_ff <= vcc_s;
        end
    end
    assign osc_halt = osc_cal_ff[BIT_OSC_HALT];
    assign xtal_rise = xtal_s && !xtal_prev_ff && !osc_halt; // R3
    assign nobk_rise = nobk_s && !nobk_prev_ff;
    assign pf_ev = vcc_s && !vcc_prev_ff;

    // control registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_cal_ff <= RST_REG8;
            int_ctrl_ff <= RST_REG8;
            alm_hour_ff <= RST_REG8;
            alm_date_ff <= RST_REG8;
        end
        else
        begin
            if (nobk_rise)
                osc_cal_ff <= osc_cal_ff & ~(8'h01 << BIT_OSC_HALT); // R4
            else if (wr_stb && wr_addr_ff == OFS_OSC_CAL)
                osc_cal_ff <= wr_data_ff & MASK_OSC; // R3
            if (wr_stb && wr_addr_ff == OFS_INT_CTRL)
                int_ctrl_ff <= wr_data_ff & MASK_INT;
            if (wr_stb && wr_addr_ff == OFS_ALM_HOURS)
                alm_hour_ff <= wr_data_ff & MASK_ALM;
            if (wr_stb && wr_addr_ff == OFS_ALM_DATE)
                alm_date_ff <= wr_data_ff & MASK_ALM;
        end
    end

    // calibrated second: first second of each minute is trimmed
    always_comb
    begin
        sec_len = 17'(XTAL_HZ);
        if (sec_ff == 8'h00)
        begin
            if (osc_cal_ff[BIT_CAL_SIGN])
                sec_len = 17'(XTAL_HZ) - {12'h000, osc_cal_ff[4:0]}; // R5
            else
                sec_len = 17'(XTAL_HZ) + {12'h000, osc_cal_ff[4:0]}; // R5
        end
    end
    assign sec_tick = xtal_rise && (sub_ff >= sec_len - 17'h00001);

    always_ff @(posedge clk)
    begin
        if (rst)
            sub_ff <= '0;
        else if (wr_stb && wr_addr_ff == OFS_SECONDS)
            sub_ff <= '0;
        else if (sec_tick)
            sub_ff <= '0;
        else if (xtal_rise)
            sub_ff <= sub_ff + 17'h00001;
    end

    // time counters; a host write wins over the tick
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sec_ff <= RST_REG8;
            min_ff <= RST_REG8;
            hour_ff <= RST_REG8;
        end
        else
        begin
            if (wr_stb && wr_addr_ff == OFS_SECONDS)
                sec_ff <= wr_data_ff & MASK_SEC;
            else if (sec_tick)
                sec_ff <= bcd_inc(sec_ff, SEC_LAST); // R1
            if (wr_stb && wr_addr_ff == OFS_MINUTES)
                min_ff <= wr_data_ff & MASK_MIN;
            else if (sec_tick && sec_ff == SEC_LAST)
                min_ff <= bcd_inc(min_ff, MIN_LAST); // R1
            if (wr_stb && wr_addr_ff == OFS_HOURS)
                hour_ff <= wr_data_ff & MASK_HOUR;
            else if (sec_tick && sec_ff == SEC_LAST && min_ff == MIN_LAST)
                hour_ff <= bcd_inc(hour_ff, HOUR_LAST); // R2
        end
    end

    // alarm compare once the time has reached hh:00:00
    always_ff @(posedge clk)
    begin
        if (rst)
            alm_chk_ff <= 1'b0;
        else
            alm_chk_ff <= sec_tick;
    end
    assign al_ev = alm_chk_ff && sec_ff == 8'h00 && min_ff == 8'h00
        && (alm_hour_ff[BIT_MASK] || alm_hour_ff[5:0] == hour_ff[5:0]) // R15
        && (alm_date_ff[BIT_MASK] || alm_date_ff[5:0] == date_bcd[5:0]); // R14

    // watchdog: 1024 crystal edges per unit
    assign wd_tick = xtal_rise && (wd_pre_ff == 10'(WDOG_UNIT_EDGES - 1));
    assign wd_ev = wd_tick && !kick_pend_ff && !wdt_pend_ff && wdt_val_ff != 6'h00
        && wd_cnt_ff == 6'h01; // R9 R17

    always_ff @(posedge clk)
    begin
        if (rst)
            wd_pre_ff <= '0;
        else if (wd_tick)
            wd_pre_ff <= '0;
        else if (xtal_rise)
            wd_pre_ff <= wd_pre_ff + 10'h001;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wdt_val_ff <= RST_WDT;
            wdt_pend_ff <= 1'b0;
            kick_pend_ff <= 1'b0;
            wd_cnt_ff <= RST_WDT;
        end
        else
        begin
            if (wr_stb && wr_addr_ff == OFS_WDOG && !wr_data_ff[BIT_LOCK])
            begin
                wdt_val_ff <= wr_data_ff[5:0]; // R7
                wdt_pend_ff <= 1'b1; // R8
            end
            else if (wd_tick)
                wdt_pend_ff <= 1'b0;
            if (wr_stb && wr_addr_ff == OFS_WDOG && wr_data_ff[BIT_KICK])
                kick_pend_ff <= 1'b1; // R6
            else if (wd_tick)
                kick_pend_ff <= 1'b0;
            if (wd_tick)
            begin
                if (kick_pend_ff || wdt_pend_ff || wd_ev)
                    wd_cnt_ff <= wdt_val_ff; // R6 R8
                else if (wdt_val_ff != 6'h00 && wd_cnt_ff != 6'h00)
                    wd_cnt_ff <= wd_cnt_ff - 6'h01; // R9
            end
        end
    end

    // event flags: a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_ff <= RST_FLAGS;
        else
        begin
            flags_ff[BIT_WDF - 5] <= wd_ev || (flags_ff[BIT_WDF - 5] && !rd_clr); // R17
            flags_ff[BIT_AF - 5] <= al_ev || (flags_ff[BIT_AF - 5] && !rd_clr); // R16
            flags_ff[BIT_PF - 5] <= pf_ev || (flags_ff[BIT_PF - 5] && !rd_clr);
        end
    end

    assign irq_ev = (wd_ev && int_ctrl_ff[BIT_WIE]) // R10
        || (al_ev && int_ctrl_ff[BIT_AIE] && (int_ctrl_ff[BIT_ABE] || !vcc_s)) // R11 R12
        || (pf_ev && int_ctrl_ff[BIT_POWERFAIL_IRQ_ENABLE]); // R18

    // interrupt output: fixed pulse or level held until flags read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            int_act_ff <= 1'b0;
            pulse_cnt_ff <= '0;
        end
        else if (irq_ev)
        begin
            int_act_ff <= 1'b1;
            pulse_cnt_ff <= '0;
        end
        else if (int_act_ff && int_ctrl_ff[BIT_PULSE])
        begin
            pulse_cnt_ff <= pulse_cnt_ff + 32'h00000001;
            if (pulse_cnt_ff >= 32'(PULSE_CYC - 1))
                int_act_ff <= 1'b0; // R19
        end
        else if (rd_clr)
            int_act_ff <= 1'b0; // R19
    end
    assign int_data = int_ctrl_ff[BIT_POL] && int_act_ff; // R13
    assign int_oe_n = !int_ctrl_ff[BIT_POL] && !int_act_ff; // R13

    a_sec_bcd_range: assert property (@(posedge clk) disable iff (rst) // R1
        (sec_ff[3:0] <= 4'h9 && sec_ff <= SEC_LAST && min_ff <= MIN_LAST))
        else $error("seconds or minutes out of bcd range");
    a_hour_range: assert property (@(posedge clk) disable iff (rst) // R2
        (hour_ff[3:0] <= 4'h9 && hour_ff <= HOUR_LAST))
        else $error("hours out of range");
    a_halt_freezes: assert property (@(posedge clk) disable iff (rst) // R3
        (osc_halt && !wr_stb) |=> $stable(sub_ff))
        else $error("timebase moved while halted");
    a_nobk_runs: assert property (@(posedge clk) disable iff (rst) // R4
        nobk_rise |=> !osc_cal_ff[BIT_OSC_HALT])
        else $error("halt bit not cleared at power-up");
    a_kick_reload: assert property (@(posedge clk) disable iff (rst) // R6
        (wd_tick && kick_pend_ff && !wr_stb) |=> (wd_cnt_ff == wdt_val_ff && !kick_pend_ff))
        else $error("strobe did not reload watchdog");
    a_wdog_reads_zero: assert property (@(posedge clk) disable iff (rst) // R7
        ($past(addr_s) == OFS_WDOG) |-> (dq_o_ff[7:6] == 2'b00))
        else $error("strobe or lock bit read back non-zero");
    a_lock_keeps: assert property (@(posedge clk) disable iff (rst) // R7
        (wr_stb && wr_addr_ff == OFS_WDOG && wr_data_ff[BIT_LOCK]) |=> $stable(wdt_val_ff))
        else $error("locked time-out was written");
    a_new_value_load: assert property (@(posedge clk) disable iff (rst) // R8
        (wd_tick && wdt_pend_ff && !wr_stb) |=> (wd_cnt_ff == $past(wdt_val_ff)))
        else $error("new time-out not loaded on tick");
    a_zero_disables: assert property (@(posedge clk) disable iff (rst) // R9
        (wdt_val_ff == 6'h00) |-> !wd_ev)
        else $error("disabled watchdog expired");
    a_wdog_irq: assert property (@(posedge clk) disable iff (rst) // R10
        (wd_ev && int_ctrl_ff[BIT_WIE]) |=> (int_act_ff && flags_ff[BIT_WDF - 5]))
        else $error("watchdog expiry did not interrupt");
    a_alarm_flag: assert property (@(posedge clk) disable iff (rst) // R16
        al_ev |=> flags_ff[BIT_AF - 5])
        else $error("alarm match did not set flag");
    a_flag_read_clear: assert property (@(posedge clk) disable iff (rst) // R17
        (rd_clr && !wd_ev && !al_ev && !pf_ev) |=> (flags_ff == 3'h0))
        else $error("flags not cleared by read");
    a_open_drain: assert property (@(posedge clk) disable iff (rst) // R13
        !int_ctrl_ff[BIT_POL] |-> (int_data == 1'b0 && int_oe_n == !int_act_ff))
        else $error("open-drain output misdriven");
    a_level_holds: assert property (@(posedge clk) disable iff (rst) // R19
        (int_act_ff && !int_ctrl_ff[BIT_PULSE] && !rd_clr) |=> int_act_ff)
        else $error("level interrupt dropped before read");

endmodule // rtc_ctrl

// file: hw/rtc_ctrl_pkg.sv
// constants for the timekeeping, alarm and watchdog register section
// assumes a 250 MHz core clock and a 32.768 kHz crystal sampled as a pin
package rtc_ctrl_pkg;
    localparam logic [16:0] OFS_FLAGS = 17'h1fff0;
    localparam logic [16:0] OFS_ALM_HOURS = 17'h1fff4;
    localparam logic [16:0] OFS_ALM_DATE = 17'h1fff5;
    localparam logic [16:0] OFS_INT_CTRL = 17'h1fff6;
    localparam logic [16:0] OFS_WDOG = 17'h1fff7;
    localparam logic [16:0] OFS_OSC_CAL = 17'h1fff8;
    localparam logic [16:0] OFS_SECONDS = 17'h1fff9;
    localparam logic [16:0] OFS_MINUTES = 17'h1fffa;
    localparam logic [16:0] OFS_HOURS = 17'h1fffb;
    localparam int BIT_OSC_HALT = 7;
    localparam int BIT_CAL_SIGN = 5;
    localparam int BIT_KICK = 7;
    localparam int BIT_LOCK = 6;
    localparam int BIT_WIE = 7;
    localparam int BIT_AIE = 6;
    localparam int BIT_POWERFAIL_IRQ_ENABLE = 5;
    localparam int BIT_ABE = 4;
    localparam int BIT_POL = 3;
    localparam int BIT_PULSE = 2;
    localparam int BIT_MASK = 7;
    localparam int BIT_WDF = 7;
    localparam int BIT_AF = 6;
    localparam int BIT_PF = 5;
    localparam logic [7:0] MASK_SEC = 8'h7f;
    localparam logic [7:0] MASK_MIN = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h3f;
    localparam logic [7:0] MASK_ALM = 8'hbf;
    localparam logic [7:0] MASK_OSC = 8'hbf;
    localparam logic [7:0] MASK_INT = 8'hfc;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [5:0] RST_WDT = 6'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam int XTAL_HZ = 32768;
    localparam int WDOG_UNIT_US = 31250;
    localparam int WDOG_UNIT_EDGES = XTAL_HZ * WDOG_UNIT_US / 1000000;
    localparam int PULSE_MS = 200;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_CYCLES = PULSE_MS * 1000000 / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bus_state_t;
endpackage

// file: verification/host_bus_model.sv
// host processor model on the byte-wide register bus: drives pins, reads data back
// assumes the device synchronises every pin and needs each pin state held several cycles
`timescale 1ns/100ps
module host_bus_model
(
    input wire logic clk,
    input wire logic [7:0] dq_rd_data,
    input wire logic dq_oe_n,
    output logic [16:0] addr,
    output logic [7:0] dq_wr_data,
    output logic e_n,
    output logic w_n,
    output logic g_n
);
    initial
    begin
        addr = 17'h00000;
        dq_wr_data = 8'h00;
        e_n = 1'b1;
        w_n = 1'b1;
        g_n = 1'b1;
    end

    // hold = cycles the strobes stay low; a large hold models a slow host
    task automatic bus_write(input logic [16:0] a, input logic [7:0] d, input int hold);
        @(posedge clk);
        addr <= a;
        dq_wr_data <= d;
        e_n <= 1'b0;
        w_n <= 1'b0;
        repeat (hold) @(posedge clk);
        e_n <= 1'b1;
        w_n <= 1'b1;
        repeat (3) @(posedge clk);
        // released data lines must not keep showing the written byte
        dq_wr_data <= ~d;
        repeat (4) @(posedge clk);
    endtask

    task automatic bus_read(input logic [16:0] a, output logic [7:0] d, input int hold);
        int n;
        @(posedge clk);
        addr <= a;
        e_n <= 1'b0;
        g_n <= 1'b0;
        n = 0;
        while (dq_oe_n !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        repeat (hold) @(posedge clk);
        d = (dq_oe_n === 1'b0) ? dq_rd_data : 8'hxx;
        e_n <= 1'b1;
        g_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule // host_bus_model

// file: verification/tb_rtc_ctrl.sv
// self-checking bench for the timekeeping, alarm and watchdog register section
// assumes xtal_clk may run far faster than a real crystal, as it is only sampled
`timescale 1ns/100ps
module tb_rtc_ctrl
    import rtc_ctrl_pkg::*;
;
    localparam int PULSE = 20;
    localparam int WD_UNIT = 1024 * 8;
    logic clk;
    logic rst;
    logic [16:0] addr;
    logic [7:0] dq_wr_data;
    logic [7:0] dq_rd_data;
    logic dq_oe_n;
    logic e_n;
    logic w_n;
    logic g_n;
    logic xtal_clk;
    logic vcc_low;
    logic nobackup_powerup;
    logic [7:0] date_bcd;
    logic int_data;
    logic int_oe_n;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;

    rtc_ctrl #(.PULSE_CYC(PULSE)) i_rtc_ctrl (.clk(clk), .rst(rst), .addr(addr),
        .dq_wr_data(dq_wr_data), .dq_rd_data(dq_rd_data), .dq_oe_n(dq_oe_n), .e_n(e_n),
        .w_n(w_n), .g_n(g_n), .xtal_clk(xtal_clk), .vcc_low(vcc_low),
        .nobackup_powerup(nobackup_powerup), .date_bcd(date_bcd), .int_data(int_data),
        .int_oe_n(int_oe_n));

    host_bus_model i_host_bus_model (.clk(clk), .dq_rd_data(dq_rd_data), .dq_oe_n(dq_oe_n),
        .addr(addr), .dq_wr_data(dq_wr_data), .e_n(e_n), .w_n(w_n), .g_n(g_n));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // crystal stand-in: 8 clk cycles per period
    initial
    begin
        xtal_clk = 1'b0;
        forever
        begin
            repeat (4) @(posedge clk);
            xtal_clk <= ~xtal_clk;
        end
    end

    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        i_host_bus_model.bus_write(a, d, 4);
    endtask

    task automatic rdchk(input logic [16:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host_bus_model.bus_read(a, d, 2);
        chk($sformatf("reg %h", a), {24'h0, d}, {24'h0, exp});
    endtask

    task automatic test_reset_values();
        rdchk(OFS_INT_CTRL, 8'h00);
        rdchk(OFS_WDOG, 8'h00);
        rdchk(OFS_OSC_CAL, 8'h00);
        rdchk(OFS_HOURS, 8'h00);
        rdchk(OFS_FLAGS, 8'h00);
        rdchk(17'h1fff1, 8'h00);
        chk("int_oe_n idle", {31'h0, int_oe_n}, 32'h1);
        chk("int_data idle", {31'h0, int_data}, 32'h0);
    endtask

    task automatic test_register_rw();
        wr(OFS_ALM_HOURS, 8'h23);
        rdchk(OFS_ALM_HOURS, 8'h23);
        i_host_bus_model.bus_write(OFS_ALM_HOURS, 8'h80, 12);
        rdchk(OFS_ALM_HOURS, 8'h80);
        wr(OFS_ALM_DATE, 8'h31);
        rdchk(OFS_ALM_DATE, 8'h31);
        wr(OFS_ALM_DATE, 8'h80);
        rdchk(OFS_ALM_DATE, 8'h80);
        wr(OFS_HOURS, 8'h23);
        rdchk(OFS_HOURS, 8'h23);
        wr(OFS_MINUTES, 8'h59);
        rdchk(OFS_MINUTES, 8'h59);
        wr(OFS_SECONDS, 8'h59);
        rdchk(OFS_SECONDS, 8'h59);
        wr(OFS_OSC_CAL, 8'hbf);
        rdchk(OFS_OSC_CAL, 8'hbf);
        @(posedge clk);
        nobackup_powerup <= 1'b1;
        repeat (6) @(posedge clk);
        nobackup_powerup <= 1'b0;
        rdchk(OFS_OSC_CAL, 8'h3f);
        wr(OFS_OSC_CAL, 8'h00);
        wr(17'h1fff1, 8'h55);
        rdchk(17'h1fff1, 8'h00);
        wr(OFS_FLAGS, 8'he0);
        rdchk(OFS_FLAGS, 8'h00);
    endtask

    // raise vcc_low for 100 cycles, counting cycles with the open-drain output pulling
    task automatic pf_event(output int lo);
        @(posedge clk);
        vcc_low <= 1'b1;
        lo = 0;
        repeat (100)
        begin
            @(posedge clk);
            if (int_oe_n === 1'b0)
                lo++;
        end
        vcc_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic test_powerfail();
        int lo;
        wr(OFS_INT_CTRL, 8'h24);
        pf_event(lo);
        chk("pulse length ok", {31'h0, lo >= PULSE - 1 && lo <= PULSE + 1}, 32'h1);
        chk("int_data open drain", {31'h0, int_data}, 32'h0);
        rdchk(OFS_FLAGS, 8'h20);
        wr(OFS_INT_CTRL, 8'h20);
        pf_event(lo);
        chk("level held", {31'h0, lo >= 90}, 32'h1);
        rdchk(OFS_FLAGS, 8'h20);
        chk("level cleared by read", {31'h0, int_oe_n}, 32'h1);
        wr(OFS_INT_CTRL, 8'h00);
        pf_event(lo);
        chk("pf masked", lo, 0);
        rdchk(OFS_FLAGS, 8'h20);
    endtask

    task automatic wait_int(output int t);
        int n;
        n = 0;
        while (int_data !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        t = cyc;
    endtask

    task automatic test_watchdog();
        int t0;
        int t1;
        int hi;
        wr(OFS_INT_CTRL, 8'h88);
        chk("push pull enable", {31'h0, int_oe_n}, 32'h0);
        wr(OFS_WDOG, 8'h81);
        rdchk(OFS_WDOG, 8'h01);
        wr(OFS_WDOG, 8'hc5);
        rdchk(OFS_WDOG, 8'h01);
        wait_int(t0);
        chk("wdog irq", {31'h0, int_data}, 32'h1);
        rdchk(OFS_FLAGS, 8'h80);
        chk("level cleared", {31'h0, int_data}, 32'h0);
        wait_int(t1);
        chk("period ok", {31'h0, t1 - t0 >= WD_UNIT - 16 && t1 - t0 <= WD_UNIT + 16}, 32'h1);
        wr(OFS_INT_CTRL, 8'h08);
        rdchk(OFS_FLAGS, 8'h80);
        hi = 0;
        repeat (WD_UNIT + 800)
        begin
            @(posedge clk);
            if (int_data === 1'b1)
                hi++;
        end
        chk("wdog irq masked", hi, 0);
        rdchk(OFS_FLAGS, 8'h80);
        wr(OFS_WDOG, 8'h00);
        rdchk(OFS_FLAGS, 8'h00);
        repeat (WD_UNIT + 800) @(posedge clk);
        rdchk(OFS_FLAGS, 8'h00);
    endtask

    initial
    begin
        rst = 1'b1;
        vcc_low = 1'b0;
        nobackup_powerup = 1'b0;
        date_bcd = 8'h15;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        test_reset_values();
        test_register_rw();
        test_powerfail();
        test_watchdog();
        report_and_stop();
    end
endmodule // tb_rtc_ctrl
